// *** rtl/fpg_defines.svh ***
`ifndef FPG_DEFINES_SVH
`define FPG_DEFINES_SVH
`define FPG_FLASH_BYTES 8192
`define FPG_PAGE_LAST 13'h01ff
`define FPG_DEV_LAST 13'h1fff
`define FPG_LOCK_ADDR 13'h1fff
`define FPG_SEC_PAGE 4'hf
`define FPG_LOCK_OPEN 8'hff
`define FPG_RO_BASE 14'h2000
`define FPG_RO_END 14'h20ff
`define FPG_RO_FILL 8'h00
`define FPG_ERASED 8'hff
`define FPG_KEY1 8'ha5
`define FPG_KEY2 8'hf1
`define FPG_CTRL_OFS 32'h0000_0000
`define FPG_KEY_OFS 32'h0000_0004
`define FPG_STAT_OFS 32'h0000_0008
`define FPG_SUP_OFS 32'h0000_000c
`define FPG_WEN_BIT 0
`define FPG_EEN_BIT 1
`define FPG_MON_EN_BIT 0
`define FPG_MON_RST_BIT 1
`define FPG_CTRL_RST 1'b0
`define FPG_SUP_RST 1'b1
`define FPG_CLK_NS 4
`define FPG_PROG_NS 40
`define FPG_PROG_CYC ((`FPG_PROG_NS + `FPG_CLK_NS - 1) / `FPG_CLK_NS)
`endif

// *** rtl/fpg_guard.sv ***
// Overview of operation
// RULE_01: erase unit is one 512-byte page
// RULE_02: no flash change without write enable
// RULE_03: page erase needs both enables set
// RULE_04: locked page count is inverted lock byte
// RULE_05: security page locked unless lock byte ff
// RULE_06: unlocked code touching locked areas: reset
// RULE_07: locked code: all but security erase, reserved
// RULE_08: read-only area allows reads only
// RULE_09: debug: unlocked full, locked device erase only
// RULE_10: programming only clears bits, one byte
// RULE_11: page erase sets bytes to ff
// RULE_12: operations self-timed, execution stalled meanwhile
// RULE_13: unlock key a5 then f1, any spacing
// RULE_14: wrong or misordered key blocks until reset
// RULE_15: attempt before unlock blocks further modification
// RULE_16: key relocks after each completed operation
// RULE_17: move write anywhere in page erases page
// RULE_18: enables persist until software clears them
// RULE_19: write without erase programs data byte
// RULE_20: software programs only erased bytes
// RULE_21: software erase sequence order
// RULE_22: software byte program sequence order
// RULE_23: erase ignores the written data byte
// RULE_24: supply monitor off during attempt: reset
// RULE_25: error reset request is one-clock pulse
// RULE_26: move write without enable leaves flash alone
//
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`include "fpg_defines.svh"
module fpg_guard (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // processor core
  input wire logic mw_req,
  input wire logic [13:0] mw_addr,
  input wire logic [7:0] mw_data,
  input wire logic [13:0] exec_addr,
  input wire logic rd_req,
  input wire logic [13:0] rd_addr,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic stall,
  output logic flash_err_rst,
  // serial debug port
  input wire logic dbg_req,
  input wire logic [1:0] dbg_op,
  input wire logic [13:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  output logic dbg_ack,
  output logic dbg_err,
  output logic [7:0] dbg_rdata
);

////////////////////////////////////////////////////////////////////////////////
// decoding functions

function automatic fpg_pkg::fpg_area_t area_of(input logic [13:0] a, input logic [7:0] lb);
  logic [7:0] n;
  n = ~lb;
  if (a >= `FPG_RO_BASE && a <= `FPG_RO_END)
    area_of = fpg_pkg::AR_RO;
  else if (a[13])
    area_of = fpg_pkg::AR_RSVD;
  else if (a[12:9] == `FPG_SEC_PAGE)
    area_of = (lb == `FPG_LOCK_OPEN) ? fpg_pkg::AR_OPEN : fpg_pkg::AR_SEC; // RULE_05
  else if ({4'h0, a[12:9]} < n)
    area_of = fpg_pkg::AR_LOCKED; // RULE_04
  else
    area_of = fpg_pkg::AR_OPEN;
endfunction

function automatic fpg_pkg::fpg_verdict_t fw_verdict(input fpg_pkg::fpg_area_t ar, input logic el,
                                                     input fpg_pkg::fpg_kind_t kd);
  case (ar)
    fpg_pkg::AR_OPEN: fw_verdict = fpg_pkg::V_OK;
    fpg_pkg::AR_LOCKED: fw_verdict = el ? fpg_pkg::V_OK : fpg_pkg::V_RESET; // RULE_06
    fpg_pkg::AR_SEC:
      if (!el)
        fw_verdict = fpg_pkg::V_RESET; // RULE_06
      else
        fw_verdict = (kd == fpg_pkg::KD_ERASE) ? fpg_pkg::V_REFUSE : fpg_pkg::V_OK; // RULE_07
    fpg_pkg::AR_RO: fw_verdict = (kd == fpg_pkg::KD_READ) ? fpg_pkg::V_OK : fpg_pkg::V_REFUSE; // RULE_08
    default: fw_verdict = fpg_pkg::V_RESET; // RULE_07
  endcase
endfunction

function automatic logic dbg_allow(input fpg_pkg::fpg_area_t ar, input fpg_pkg::fpg_kind_t kd);
  if (kd == fpg_pkg::KD_DEV)
    dbg_allow = 1'b1; // RULE_09
  else
    case (ar)
      fpg_pkg::AR_OPEN: dbg_allow = 1'b1; // RULE_09
      fpg_pkg::AR_RO: dbg_allow = (kd == fpg_pkg::KD_READ); // RULE_08
      default: dbg_allow = 1'b0; // RULE_09
    endcase
endfunction

////////////////////////////////////////////////////////////////////////////////
// storage and state

logic [7:0] mem [0:`FPG_FLASH_BYTES-1];
fpg_pkg::fpg_key_t key_st;
fpg_pkg::fpg_key_t next_key;
fpg_pkg::fpg_op_t op_st;
fpg_pkg::fpg_op_t next_op;
logic [12:0] cnt;
logic [12:0] op_last;
logic [12:0] op_base;
logic op_sw;
logic wen;
logic een;
logic mon_en;
logic mon_rst;
logic [3:0] wr_sel;

////////////////////////////////////////////////////////////////////////////////
// ahb-lite register decode

wire ahb_take = hsel & htrans[1] & hready;
wire sel_ctrl = (haddr == `FPG_CTRL_OFS);
wire sel_key = (haddr == `FPG_KEY_OFS);
wire sel_stat = (haddr == `FPG_STAT_OFS);
wire sel_sup = (haddr == `FPG_SUP_OFS);
wire ctrl_we = wr_sel[0];
wire key_we = wr_sel[1];
wire sup_we = wr_sel[3];
wire [7:0] key_in = hwdata[7:0];
wire [7:0] lock_byte = mem[`FPG_LOCK_ADDR];
wire busy = (op_st != fpg_pkg::OP_IDLE);
wire [31:0] rd_mux = sel_ctrl ? {30'h0, een, wen} :
                     sel_key ? {28'h0, key_st} :
                     sel_stat ? {16'h0, lock_byte, 7'h0, busy} :
                     sel_sup ? {30'h0, mon_rst, mon_en} : 32'h0;

always_ff @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    hreadyout <= 1'b1;
    hresp <= 1'b0;
    hrdata <= 32'h0;
    wr_sel <= 4'h0;
  end
  else
  begin
    hreadyout <= 1'b1;
    hresp <= 1'b0;
    if (ahb_take && !hwrite)
      hrdata <= rd_mux;
    wr_sel <= (ahb_take && hwrite) ? {sel_sup, sel_stat, sel_key, sel_ctrl} : 4'h0;
  end
end

always_ff @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    wen <= `FPG_CTRL_RST;
    een <= `FPG_CTRL_RST;
    mon_en <= `FPG_SUP_RST;
    mon_rst <= `FPG_SUP_RST;
  end
  else
  begin
    if (ctrl_we)
    begin
      wen <= hwdata[`FPG_WEN_BIT]; // RULE_18
      een <= hwdata[`FPG_EEN_BIT]; // RULE_18
    end
    if (sup_we)
    begin
      mon_en <= hwdata[`FPG_MON_EN_BIT];
      mon_rst <= hwdata[`FPG_MON_RST_BIT];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// access classification

wire exec_locked = (area_of(exec_addr, lock_byte) == fpg_pkg::AR_LOCKED) ||
                   (area_of(exec_addr, lock_byte) == fpg_pkg::AR_SEC);
wire sw_try = mw_req & wen & !busy; // RULE_26
wire sup_ok = mon_en & mon_rst;
wire fpg_pkg::fpg_kind_t mw_kind = een ? fpg_pkg::KD_ERASE : fpg_pkg::KD_WRITE; // RULE_03
wire fpg_pkg::fpg_verdict_t mw_vd = fw_verdict(area_of(mw_addr, lock_byte), exec_locked, mw_kind);
wire sw_err = sw_try & (!sup_ok | (mw_vd == fpg_pkg::V_RESET)); // RULE_24
wire sw_go = sw_try & (key_st == fpg_pkg::K_OPEN) & sup_ok & (mw_vd == fpg_pkg::V_OK); // RULE_02
wire rd_go = rd_req & !busy;
wire fpg_pkg::fpg_verdict_t rd_vd = fw_verdict(area_of(rd_addr, lock_byte), exec_locked, fpg_pkg::KD_READ);
wire rd_err = rd_go & (rd_vd == fpg_pkg::V_RESET); // RULE_06
wire [7:0] rd_byte = rd_addr[13] ? `FPG_RO_FILL : mem[rd_addr[12:0]];

wire fpg_pkg::fpg_kind_t dbg_kind = fpg_pkg::fpg_kind_t'(dbg_op);
wire dbg_go = dbg_req & !busy & !sw_go;
wire dbg_ok = dbg_go & dbg_allow(area_of(dbg_addr, lock_byte), dbg_kind); // RULE_09
wire [7:0] dbg_byte = dbg_addr[13] ? `FPG_RO_FILL : mem[dbg_addr[12:0]];

////////////////////////////////////////////////////////////////////////////////
// operation start selection

wire prog_go = (sw_go & !een) | (dbg_ok & (dbg_kind == fpg_pkg::KD_WRITE)); // RULE_19
wire perase_go = (sw_go & een) | (dbg_ok & (dbg_kind == fpg_pkg::KD_ERASE)); // RULE_17
wire dev_go = dbg_ok & (dbg_kind == fpg_pkg::KD_DEV) & !sw_go;
wire [13:0] p_addr = sw_go ? mw_addr : dbg_addr;
wire [7:0] p_data = sw_go ? mw_data : dbg_wdata;
wire op_done = busy & (cnt == op_last);
wire sw_done = op_done & op_sw;

always_comb
begin
  next_key = key_st;
  case (key_st)
    fpg_pkg::K_WAIT1:
      if (key_we)
        next_key = (key_in == `FPG_KEY1) ? fpg_pkg::K_WAIT2 : fpg_pkg::K_BLOCK; // RULE_13
      else if (sw_try)
        next_key = fpg_pkg::K_BLOCK; // RULE_15
    fpg_pkg::K_WAIT2:
      if (key_we)
        next_key = (key_in == `FPG_KEY2) ? fpg_pkg::K_OPEN : fpg_pkg::K_BLOCK; // RULE_14
      else if (sw_try)
        next_key = fpg_pkg::K_BLOCK; // RULE_15
    fpg_pkg::K_OPEN:
      if (sw_done)
        next_key = fpg_pkg::K_WAIT1; // RULE_16
      else if (key_we)
        next_key = fpg_pkg::K_BLOCK; // RULE_14
    fpg_pkg::K_BLOCK: next_key = fpg_pkg::K_BLOCK; // RULE_14
    default: next_key = fpg_pkg::K_BLOCK;
  endcase
end

always_comb
begin
  next_op = op_st;
  case (op_st)
    fpg_pkg::OP_IDLE:
      if (prog_go)
        next_op = fpg_pkg::OP_PROG;
      else if (perase_go || dev_go)
        next_op = fpg_pkg::OP_ERASE;
    fpg_pkg::OP_PROG:
      if (op_done)
        next_op = fpg_pkg::OP_IDLE;
    fpg_pkg::OP_ERASE:
      if (op_done)
        next_op = fpg_pkg::OP_IDLE;
    default: next_op = fpg_pkg::OP_IDLE;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// sequencer

always_ff @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    key_st <= fpg_pkg::K_WAIT1;
    op_st <= fpg_pkg::OP_IDLE;
    cnt <= 13'h0;
    op_last <= 13'h0;
    op_base <= 13'h0;
    op_sw <= 1'b0;
    stall <= 1'b0;
  end
  else
  begin
    key_st <= next_key;
    op_st <= next_op;
    stall <= (next_op != fpg_pkg::OP_IDLE); // RULE_12
    if (!busy)
    begin
      cnt <= 13'h0;
      op_sw <= sw_go;
      op_base <= {p_addr[12:9], 9'h0}; // RULE_01
      if (prog_go)
        op_last <= 13'(`FPG_PROG_CYC - 1); // RULE_12
      else if (dev_go)
      begin
        op_last <= `FPG_DEV_LAST;
        op_base <= 13'h0;
      end
      else
        op_last <= `FPG_PAGE_LAST; // RULE_01
    end
    else if (!op_done)
      cnt <= cnt + 13'h1;
  end
end

always_ff @(posedge hclk)
begin
  if (prog_go)
    mem[p_addr[12:0]] <= mem[p_addr[12:0]] & p_data; // RULE_10
  else if (op_st == fpg_pkg::OP_ERASE)
    mem[op_base | cnt] <= `FPG_ERASED; // RULE_11 RULE_23
end

////////////////////////////////////////////////////////////////////////////////
// answers

always_ff @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    rd_valid <= 1'b0;
    rd_data <= 8'h00;
    flash_err_rst <= 1'b0;
    dbg_ack <= 1'b0;
    dbg_err <= 1'b0;
    dbg_rdata <= 8'h00;
  end
  else
  begin
    rd_valid <= rd_go & !rd_err;
    if (rd_go && !rd_err)
      rd_data <= rd_byte;
    flash_err_rst <= sw_err | rd_err; // RULE_25
    dbg_ack <= dbg_req;
    dbg_err <= dbg_req & !dbg_ok;
    if (dbg_ok && dbg_kind == fpg_pkg::KD_READ)
      dbg_rdata <= dbg_byte;
  end
end

////////////////////////////////////////////////////////////////////////////////
// assertions

sequence s_sw_start;
  sw_go && !busy;
endsequence
sequence s_sw_finish;
  sw_done;
endsequence
property p_block_sticky;
  @(posedge hclk) disable iff (!hresetn)
  (key_st == fpg_pkg::K_BLOCK) |=> (key_st == fpg_pkg::K_BLOCK);
endproperty
a_block_sticky: assert property (p_block_sticky) else $error("key block released"); // RULE_14
property p_start_needs_key;
  @(posedge hclk) disable iff (!hresetn)
  s_sw_start |-> (key_st == fpg_pkg::K_OPEN) && wen;
endproperty
a_start_needs_key: assert property (p_start_needs_key) else $error("op started while locked"); // RULE_02
property p_erase_needs_een;
  @(posedge hclk) disable iff (!hresetn)
  s_sw_start ##1 (op_st == fpg_pkg::OP_ERASE) |-> $past(een) && $past(wen);
endproperty
a_erase_needs_een: assert property (p_erase_needs_een) else $error("erase without both enables"); // RULE_03
property p_relock;
  @(posedge hclk) disable iff (!hresetn)
  s_sw_finish |=> (key_st == fpg_pkg::K_WAIT1) && !busy;
endproperty
a_relock: assert property (p_relock) else $error("key not relocked"); // RULE_16
property p_page_len;
  @(posedge hclk) disable iff (!hresetn)
  (op_st == fpg_pkg::OP_ERASE) && op_done && (op_base[12:9] != 4'h0 || op_sw) |-> cnt == 13'h01ff;
endproperty
a_page_len: assert property (p_page_len) else $error("page erase length wrong"); // RULE_01
property p_stall;
  @(posedge hclk) disable iff (!hresetn)
  stall == busy;
endproperty
a_stall: assert property (p_stall) else $error("stall not matching operation"); // RULE_12
property p_err_pulse;
  @(posedge hclk) disable iff (!hresetn)
  flash_err_rst |=> !flash_err_rst || $past(sw_err | rd_err);
endproperty
a_err_pulse: assert property (p_err_pulse) else $error("error reset pulse too long"); // RULE_25
property p_supply;
  @(posedge hclk) disable iff (!hresetn)
  sw_try && !dbg_req && !(mon_en && mon_rst) |=> flash_err_rst ##1 !stall;
endproperty
a_supply: assert property (p_supply) else $error("supply fault not reset"); // RULE_24
property p_wen_hold;
  @(posedge hclk) disable iff (!hresetn)
  $fell(wen) |-> $past(ctrl_we);
endproperty
a_wen_hold: assert property (p_wen_hold) else $error("write enable cleared by hardware"); // RULE_18
property p_no_enable;
  @(posedge hclk) disable iff (!hresetn)
  mw_req && !wen && !dbg_req && !busy && !key_we |=> (op_st == fpg_pkg::OP_IDLE) && $stable(key_st);
endproperty
a_no_enable: assert property (p_no_enable) else $error("move write without enable acted"); // RULE_26
endmodule

// *** rtl/fpg_pkg.sv ***
package fpg_pkg;
  typedef enum logic [3:0] {
    K_WAIT1 = 4'b0001,
    K_WAIT2 = 4'b0010,
    K_OPEN = 4'b0100,
    K_BLOCK = 4'b1000
  } fpg_key_t;
  typedef enum logic [2:0] {
    OP_IDLE = 3'b001,
    OP_PROG = 3'b010,
    OP_ERASE = 3'b100
  } fpg_op_t;
  typedef enum logic [2:0] {
    AR_OPEN = 3'h0,
    AR_LOCKED = 3'h1,
    AR_SEC = 3'h2,
    AR_RO = 3'h3,
    AR_RSVD = 3'h4
  } fpg_area_t;
  typedef enum logic [1:0] {
    KD_READ = 2'h0,
    KD_WRITE = 2'h1,
    KD_ERASE = 2'h2,
    KD_DEV = 2'h3
  } fpg_kind_t;
  typedef enum logic [1:0] {
    V_OK = 2'h0,
    V_REFUSE = 2'h1,
    V_RESET = 2'h2
  } fpg_verdict_t;
endpackage

// *** testbench/fpg_core_model.sv ***
`timescale 1ns/100ps
module fpg_core_model (
  // clock
  input wire logic hclk,
  // core side
  output logic mw_req,
  output logic [13:0] mw_addr,
  output logic [7:0] mw_data,
  output logic [13:0] exec_addr,
  output logic rd_req,
  output logic [13:0] rd_addr,
  // debug side
  output logic dbg_req,
  output logic [1:0] dbg_op,
  output logic [13:0] dbg_addr,
  output logic [7:0] dbg_wdata
);
  initial
  begin
    mw_req = 1'b0;
    mw_addr = 14'h0000;
    mw_data = 8'h00;
    exec_addr = 14'h0000;
    rd_req = 1'b0;
    rd_addr = 14'h0000;
    dbg_req = 1'b0;
    dbg_op = 2'h0;
    dbg_addr = 14'h0000;
    dbg_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // one move write; released lines show the inverse
  task automatic mw(input logic [13:0] e, a, input logic [7:0] d);
    @(posedge hclk);
    exec_addr <= e;
    mw_req <= 1'b1;
    mw_addr <= a;
    mw_data <= d;
    @(posedge hclk);
    mw_req <= 1'b0;
    mw_addr <= ~a;
    mw_data <= ~d;
  endtask
  // one flash read
  task automatic rd(input logic [13:0] e, a);
    @(posedge hclk);
    exec_addr <= e;
    rd_req <= 1'b1;
    rd_addr <= a;
    @(posedge hclk);
    rd_req <= 1'b0;
    rd_addr <= ~a;
  endtask
  // one debug port request
  task automatic dbg(input logic [1:0] op, input logic [13:0] a, input logic [7:0] d);
    @(posedge hclk);
    dbg_req <= 1'b1;
    dbg_op <= op;
    dbg_addr <= a;
    dbg_wdata <= d;
    @(posedge hclk);
    dbg_req <= 1'b0;
    dbg_addr <= ~a;
    dbg_wdata <= ~d;
  endtask
endmodule

// *** testbench/fpg_guard_tb.sv ***
`timescale 1ns/100ps
`include "fpg_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module fpg_guard_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans, dbg_op;
  logic mw_req, rd_req, rd_valid, stall, flash_err_rst, dbg_req, dbg_ack, dbg_err;
  logic [13:0] mw_addr, exec_addr, rd_addr, dbg_addr, a, ex;
  logic [7:0] mw_data, rd_data, dbg_wdata, dbg_rdata, d, b;
  int n_errors, compares, seed;
  fpg_guard i_fpg_guard (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mw_req, .mw_addr, .mw_data, .exec_addr, .rd_req,
    .rd_addr, .rd_valid, .rd_data, .stall, .flash_err_rst, .dbg_req, .dbg_op, .dbg_addr, .dbg_wdata,
    .dbg_ack, .dbg_err, .dbg_rdata);
  fpg_core_model i_fpg_core_model (.hclk, .mw_req, .mw_addr, .mw_data, .exec_addr, .rd_req, .rd_addr,
    .dbg_req, .dbg_op, .dbg_addr, .dbg_wdata);
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo(input bit t);
    if (t)
    begin
      n_errors++;
      $display("MISMATCH %0t timeout", $time);
      end_of_test();
    end
  endtask
  task automatic rdy;
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 99);
    tmo(i == 99);
  endtask
  task automatic ahb(input logic w, input logic [31:0] ad, wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rv = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  task automatic rchk(input logic [31:0] ad, x);
    ahb(1'b0, ad, 32'h0000_0000);
    `CHK(rv, x)
  endtask
  task automatic stw(input int x);
    int i;
    i = 0;
    while (stall === 1'b1 && i < 9000)
    begin
      @(posedge hclk);
      #1;
      i++;
    end
    tmo(i == 9000);
    if (x >= 0)
      `CHK(i, x)
  endtask
  task automatic mw(input logic [13:0] ma, input logic [7:0] md, input int x);
    i_fpg_core_model.mw(ex, ma, md);
    #1;
    stw(x);
  endtask
  task automatic key;
    ahb(1'b1, `FPG_KEY_OFS, {24'h0, `FPG_KEY1});
    ahb(1'b1, `FPG_KEY_OFS, {24'h0, `FPG_KEY2});
  endtask
  task automatic prog(input logic [13:0] ma, input logic [7:0] md, input logic [31:0] c, input int x);
    key();
    ahb(1'b1, `FPG_CTRL_OFS, c);
    mw(ma, md, x);
  endtask
  task automatic crd(input logic [13:0] ra, input logic er, input logic [7:0] x);
    i_fpg_core_model.rd(ex, ra);
    #1;
    `CHK(flash_err_rst, er)
    `CHK(rd_valid, ~er)
    if (!er)
      `CHK(rd_data, x)
  endtask
  task automatic dr(input logic [1:0] op, input logic [13:0] da, input logic [7:0] wd, input logic er,
    input logic [7:0] x);
    i_fpg_core_model.dbg(op, da, wd);
    #1;
    `CHK(dbg_ack, 1'b1)
    `CHK(dbg_err, er)
    if (op == 2'h0 && !er)
      `CHK(dbg_rdata, x)
    stw(-1);
  endtask
  task automatic rst;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 85;
    n_errors = 0;
    compares = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ex = 14'h0a00;
    rst();
    rchk(`FPG_CTRL_OFS, 32'h0);
    rchk(`FPG_KEY_OFS, 32'h1);
    rchk(`FPG_SUP_OFS, 32'h3);
    rchk(32'h0000_0040, 32'h0);
    dr(2'h3, 14'h0000, 8'h00, 1'b0, 8'h00);
    a = {5'h04, 9'($random(seed))};
    d = 8'($random(seed));
    b = 8'($random(seed));
    dr(2'h0, a, 8'h00, 1'b0, `FPG_ERASED);
    prog(a, d, 32'h1, 10);
    rchk(`FPG_KEY_OFS, 32'h1);
    rchk(`FPG_CTRL_OFS, 32'h1);
    crd(a, 1'b0, d);
    prog(a, b, 32'h1, 10);
    crd(a, 1'b0, d & b);
    crd(a ^ 14'h0001, 1'b0, `FPG_ERASED);
    prog(14'h0a00, d, 32'h1, 10);
    prog({5'h04, 9'($random(seed))}, b, 32'h3, 512);
    crd(a, 1'b0, `FPG_ERASED);
    crd(14'h09ff, 1'b0, `FPG_ERASED);
    crd(14'h0a00, 1'b0, d);
    ahb(1'b1, `FPG_CTRL_OFS, 32'h0);
    mw(a, 8'h00, 0);
    rchk(`FPG_KEY_OFS, 32'h1);
    crd(a, 1'b0, `FPG_ERASED);
    prog(a, 8'h00, 32'h2, 0);
    rchk(`FPG_KEY_OFS, 32'h4);
    ahb(1'b1, `FPG_CTRL_OFS, 32'h1);
    mw(a, 8'h5a, 10);
    mw(a, 8'h00, 0);
    rchk(`FPG_KEY_OFS, 32'h8);
    key();
    rchk(`FPG_KEY_OFS, 32'h8);
    mw(a, 8'h00, 0);
    crd(a, 1'b0, 8'h5a);
    rst();
    ahb(1'b1, `FPG_KEY_OFS, {24'h0, `FPG_KEY2});
    rchk(`FPG_KEY_OFS, 32'h8);
    rst();
    ahb(1'b1, `FPG_SUP_OFS, 32'h1);
    key();
    ahb(1'b1, `FPG_CTRL_OFS, 32'h1);
    i_fpg_core_model.mw(ex, a, 8'h00);
    #1;
    `CHK(flash_err_rst, 1'b1)
    @(posedge hclk);
    #1;
    `CHK(flash_err_rst, 1'b0)
    rst();
    prog(`FPG_LOCK_ADDR, 8'hfd, 32'h1, 10);
    rchk(`FPG_STAT_OFS, 32'h0000_fd00);
    crd(14'h0010, 1'b1, 8'h00);
    crd(14'h1e00, 1'b1, 8'h00);
    crd(14'h0400, 1'b0, `FPG_ERASED);
    crd(14'h2000, 1'b0, `FPG_RO_FILL);
    ex = 14'h0000;
    crd(14'h0200, 1'b0, `FPG_ERASED);
    crd(`FPG_LOCK_ADDR, 1'b0, 8'hfd);
    crd(14'h2100, 1'b1, 8'h00);
    prog(14'h0200, 8'h00, 32'h3, 512);
    prog(14'h1e00, 8'h00, 32'h3, 0);
    dr(2'h0, 14'h0000, 8'h00, 1'b1, 8'h00);
    dr(2'h1, 14'h0400, 8'h3c, 1'b0, 8'h00);
    dr(2'h0, 14'h0400, 8'h00, 1'b0, 8'h3c);
    dr(2'h2, 14'h0400, 8'h00, 1'b0, 8'h00);
    dr(2'h0, 14'h0400, 8'h00, 1'b0, `FPG_ERASED);
    dr(2'h0, 14'h20ff, 8'h00, 1'b0, `FPG_RO_FILL);
    dr(2'h1, 14'h2000, 8'h00, 1'b1, 8'h00);
    dr(2'h0, 14'h3fff, 8'h00, 1'b1, 8'h00);
    dr(2'h2, 14'h0000, 8'h00, 1'b1, 8'h00);
    dr(2'h3, 14'h0000, 8'h00, 1'b0, 8'h00);
    dr(2'h0, 14'h1e00, 8'h00, 1'b0, `FPG_ERASED);
    end_of_test();
  end
endmodule
